// *** rtl/link_codec.sv ***
// serial link codec: transmitter, receiver, cascade capture and register slave
`timescale 1ns/10ps
// ------------------------------------------------------------------
// Notes on behaviour
// - 8-bit width: two 5-bit symbols, 10 bits
// - 9-bit width: 6-bit plus 5-bit, 11 bits
// - 10-bit width: two 6-bit symbols, 12 bits
// - sixteen (5-bit) or thirty-two (6-bit) data codes, command marks, rest invalid
// - every serial bit NRZI: one toggles line
// - coding keeps frequent line transitions
// - receiver undoes NRZI and block code exactly
// - idle byte periods carry sync
// - local mode decodes every byte continuously
// - enabled receiver captures next non-sync, flags it
// - hold symbol until sync or enable low
// - flag drops on half sync, sync, enable low
// - release to output latch next byte cycle
// - async strobe latched, moved at byte boundary
// - two byte buffer, host paces by acknowledge
// - byte clock falling edge marks byte boundary
// - strobe near boundary never loses byte
// - receiver byte clock pulses never too short
// - realignment may drop partial byte, sync decodes
// - width select splits twelve parallel lines
// - violation held until next valid decode
// ------------------------------------------------------------------
module link_codec
  import link_codec_pkg::*;
(
  input  wire logic        CORE_CLK,
  input  wire logic        SYS_RST,
  input  wire logic [3:0]  ADDRESS,
  input  wire logic        READ,
  input  wire logic        WRITE,
  input  wire logic [31:0] WRITEDATA,
  output logic      [31:0] READDATA,
  output logic             WAITREQUEST,
  input  wire logic        INPUT_STROBE,
  input  wire logic [11:0] TX_LINES,
  output logic             TX_ACK,
  output logic             TX_BYTE_CLK,
  output logic             SERIAL_OUT,
  input  wire logic        SERIAL_IN_POS,
  input  wire logic        SERIAL_IN_NEG,
  input  wire logic        CAPTURE_ENABLE_IN,
  output logic             CAPTURED_FLAG_OUT,
  output logic      [11:0] RX_LINES,
  output logic             DATA_OUT_STROBE,
  output logic             COMMAND_OUT_STROBE,
  output logic             CODE_VIOLATION_OUT,
  output logic             RX_BYTE_CLK
);

  // ----------------------------------------------------------------
  // state record
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        stb_s1, stb_s2, stb_s3;  // strobe synchroniser and edge tap
    logic [11:0] lin_s1, lin_s2;          // parallel lines synchroniser
    logic        pos_s1, pos_s2;          // serial input, positive leg
    logic        neg_s1, neg_s2;          // serial input, negative leg
    logic        cen_s1, cen_s2;          // capture enable synchroniser
    logic [1:0]  ws;                      // width select
    logic        cascade;                 // cascade capture mode
    logic        ovf;                     // sticky buffer overflow
    logic [11:0] q0, q1;                  // two-byte transmit buffer
    logic [1:0]  qcnt;                    // buffer fill
    logic        ack_owed;                // acknowledge deferred to next pop
    logic        ack;                     // acknowledge pulse
    logic [3:0]  tx_bit;                  // bit position in byte
    logic [11:0] tx_sh;                   // serial pattern, msb goes first
    logic        tx_line;                 // NRZI line level
    logic        tx_clk;                  // transmitter byte clock
    logic        rx_lvl;                  // last received line level
    logic [11:0] win;                     // received bit window
    logic [3:0]  rx_bit;                  // receive bit position
    logic        aligned;                 // byte boundary known
    logic        cap;                     // captured flag
    logic [1:0]  held_k;                  // held symbol kind
    logic [9:0]  held_v;                  // held symbol value
    logic        rel_pend;                // release at next boundary
    logic [11:0] rx_lines;                // output latch
    logic        dstb, cstb, viol;        // strobes and violation
    logic        rx_clk;                  // receiver byte clock out
    logic [3:0]  lvl_cnt;                 // cycles at current clock level
    logic [31:0] rdata;                   // bus read data
    logic        wait_r;                  // bus wait request
  } state_t;

  state_t s_r;    // registered state
  state_t s_nxt;  // next state

  // ----------------------------------------------------------------
  // geometry helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] hi_w(input logic [1:0] ws);
    hi_w = (ws == WS_9 || ws == WS_10) ? SYM5_W : SYM4_W;
  endfunction : hi_w

  function automatic logic [3:0] lo_w(input logic [1:0] ws);
    lo_w = (ws == WS_10) ? SYM5_W : SYM4_W;
  endfunction : lo_w

  // data field mask of the twelve lines
  function automatic logic [11:0] dmask(input logic [1:0] ws);
    dmask = 12'hFFF >> (SH_W - hi_w(ws) - lo_w(ws) + 4'h2);
  endfunction : dmask

  // encode one data half to its symbol, 5 or 6 bits wide
  function automatic logic [5:0] enc_half(input logic [4:0] v, input logic [3:0] w);
    enc_half = (w == SYM5_W) ? ENC5_TAB[v] : {1'b0, ENC4_TAB[v[3:0]]};
  endfunction : enc_half

  // decode a symbol: bit 5 set when valid, value below
  function automatic logic [5:0] dec_half(input logic [5:0] c, input logic [3:0] w);
    dec_half = 6'h00;
    for (int i = 0; i < 32; i++) begin
      if (w == SYM5_W && ENC5_TAB[i] == c) dec_half = {1'b1, 5'(i)};
      if (w == SYM4_W && i < 16 && {1'b0, ENC4_TAB[i[3:0]]} == c) dec_half = {1'b1, 5'(i)};
    end
  endfunction : dec_half

  // sync pattern right-aligned
  function automatic logic [11:0] sync_pat(input logic [1:0] ws);
    logic [5:0] h;
    logic [5:0] l;
    h = (hi_w(ws) == SYM5_W) ? SYNC_HI6 : SYNC_HI5;
    l = (lo_w(ws) == SYM5_W) ? SYNC_LO6 : SYNC_LO5;
    sync_pat = ({6'h00, h} << lo_w(ws)) | {6'h00, l};
  endfunction : sync_pat

  // encode twelve lines into a right-aligned serial pattern
  function automatic logic [11:0] encode(input logic [11:0] ln, input logic [1:0] ws);
    logic [3:0]  hw;
    logic [3:0]  lw;
    logic [11:0] dm;
    logic [11:0] cmd;
    logic [5:0]  h;
    logic [5:0]  l;
    hw  = hi_w(ws);
    lw  = lo_w(ws);
    dm  = dmask(ws);
    cmd = (ln & ~dm) >> (hw + lw - 4'h2);
    if (cmd != 12'h000) begin
      h = (hw == SYM5_W) ? CMD_MARK6 : CMD_MARK5;
      l = enc_half(cmd[4:0], lw);
    end else begin
      h = enc_half(5'((ln & dm) >> (lw - 4'h1)), hw);
      l = enc_half(5'(ln & (dm >> (hw - 4'h1))), lw);
    end
    encode = ({6'h00, h} << lw) | {6'h00, l};
  endfunction : encode

  // decode a right-aligned pattern into {kind, value}
  function automatic logic [11:0] decode(input logic [11:0] p, input logic [1:0] ws);
    logic [3:0] hw;
    logic [3:0] lw;
    logic [5:0] h;
    logic [5:0] l;
    logic [5:0] dh;
    logic [5:0] dl;
    hw = hi_w(ws);
    lw = lo_w(ws);
    h  = 6'(p >> lw);
    l  = 6'(p & (12'hFFF >> (SH_W - lw)));
    dh = dec_half(h, hw);
    dl = dec_half(l, lw);
    if (p == sync_pat(ws))
      decode = {K_SYNC, 10'h000};
    else if (h == ((hw == SYM5_W) ? CMD_MARK6 : CMD_MARK5) && dl[5] && dl[4:0] != 5'h00
             && {7'h00, dl[4:0]} < (12'h001 << (SH_W - hw - lw + 4'h2)))
      decode = {K_CMD, 5'h00, dl[4:0]};
    else if (dh[5] && dl[5])
      decode = {K_DATA, 10'((({5'h00, dh[4:0]}) << (lw - 4'h1)) | {5'h00, dl[4:0]})};
    else
      decode = {K_BAD, 10'h000};
  endfunction : decode

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  logic [3:0]  len;       // serial bits per byte
  logic [3:0]  hw;        // first symbol width
  logic        stb_edge;  // strobe rising edge, synchronised
  logic        tx_bnd;    // last bit of transmit byte
  logic        pop;       // encoder takes a buffered byte
  logic [1:0]  cnt_mid;   // fill after pop
  logic        lvl;       // received line level
  logic        rbit;      // NRZI decoded bit
  logic [11:0] w;         // window including newest bit
  logic [11:0] sym;       // byte candidate
  logic        sync_hit;  // window holds sync
  logic        rx_bnd;    // receive byte boundary
  logic        half_sync; // first half of sync at mid byte
  logic [11:0] dec;       // decoded kind and value
  logic        dgo;       // deliver to output latch
  logic [1:0]  dk;        // delivered kind
  logic [9:0]  dv;        // delivered value
  logic        nom;       // nominal receive byte clock level

  // one process computes the whole next state
  always_comb begin
    s_nxt     = s_r;
    len       = hi_w(s_r.ws) + lo_w(s_r.ws);
    hw        = hi_w(s_r.ws);
    dgo       = 1'b0;
    dk        = K_DATA;
    dv        = 10'h000;
    // input synchronisers
    s_nxt.stb_s1 = INPUT_STROBE;
    s_nxt.stb_s2 = s_r.stb_s1;
    s_nxt.stb_s3 = s_r.stb_s2;
    s_nxt.lin_s1 = TX_LINES;
    s_nxt.lin_s2 = s_r.lin_s1;
    s_nxt.pos_s1 = SERIAL_IN_POS;
    s_nxt.pos_s2 = s_r.pos_s1;
    s_nxt.neg_s1 = SERIAL_IN_NEG;
    s_nxt.neg_s2 = s_r.neg_s1;
    s_nxt.cen_s1 = CAPTURE_ENABLE_IN;
    s_nxt.cen_s2 = s_r.cen_s1;
    s_nxt.ack    = 1'b0;
    s_nxt.dstb   = 1'b0;
    s_nxt.cstb   = 1'b0;

    // bus slave: answer one cycle after the request is seen
    if ((READ || WRITE) && s_r.wait_r) begin
      s_nxt.wait_r = 1'b0;
      case (ADDRESS)
        REG_CTRL:     s_nxt.rdata = {29'h0, s_r.cascade, s_r.ws};
        REG_STATUS:   s_nxt.rdata = {26'h0, s_r.qcnt, s_r.ovf, s_r.cap, s_r.aligned, s_r.viol};
        REG_RX_LINES: s_nxt.rdata = {20'h0, s_r.rx_lines};
        default:      s_nxt.rdata = RD_UNMAPPED;
      endcase
    end else begin
      s_nxt.wait_r = 1'b1;
    end
    // writes take effect at the edge that completes the request
    if (WRITE && !s_r.wait_r) begin
      if (ADDRESS == REG_CTRL) begin
        s_nxt.ws      = WRITEDATA[CTRL_WS_LSB +: 2];
        s_nxt.cascade = WRITEDATA[CTRL_CASCADE];
      end
      if (ADDRESS == REG_STATUS && WRITEDATA[STAT_OVERFLOW]) s_nxt.ovf = 1'b0;
    end

    // transmitter: byte boundary loads data or sync
    stb_edge = s_r.stb_s2 & ~s_r.stb_s3;
    tx_bnd   = (s_r.tx_bit == len - 4'h1);
    pop      = tx_bnd && (s_r.qcnt != 2'h0);
    cnt_mid  = s_r.qcnt - {1'b0, pop};
    if (tx_bnd) begin
      s_nxt.tx_bit = 4'h0;
      if (pop) begin
        s_nxt.tx_sh = encode(s_r.q0, s_r.ws) << (SH_W - len);
        s_nxt.q0    = s_r.q1;
      end else begin
        s_nxt.tx_sh = sync_pat(s_r.ws) << (SH_W - len);
      end
      if (pop && s_r.ack_owed) begin
        s_nxt.ack      = 1'b1;
        s_nxt.ack_owed = 1'b0;
      end
    end else begin
      s_nxt.tx_bit = s_r.tx_bit + 4'h1;
      s_nxt.tx_sh  = s_r.tx_sh << 1;
    end
    // a strobe in the boundary cycle joins the buffer behind the pop
    if (stb_edge) begin
      if (cnt_mid == 2'h2) begin
        s_nxt.ovf = 1'b1;
      end else begin
        if (cnt_mid == 2'h0) s_nxt.q0 = s_r.lin_s2;
        else                 s_nxt.q1 = s_r.lin_s2;
        if (cnt_mid == 2'h0) s_nxt.ack = 1'b1;
        else                 s_nxt.ack_owed = 1'b1;
      end
    end
    s_nxt.qcnt    = cnt_mid + {1'b0, stb_edge && cnt_mid != 2'h2};
    s_nxt.tx_line = s_r.tx_line ^ s_r.tx_sh[SH_W - 4'h1];
    s_nxt.tx_clk  = (s_nxt.tx_bit >= (len >> 1));

    // receiver: NRZI decode and byte framing
    lvl          = (s_r.pos_s2 != s_r.neg_s2) ? s_r.pos_s2 : s_r.rx_lvl;
    rbit         = lvl ^ s_r.rx_lvl;
    s_nxt.rx_lvl = lvl;
    w            = {s_r.win[10:0], rbit};
    s_nxt.win    = w;
    sym          = w & (12'hFFF >> (SH_W - len));
    sync_hit     = (sym == sync_pat(s_r.ws));
    // sync anywhere resets the boundary; partial byte is dropped
    rx_bnd       = (s_r.rx_bit == len - 4'h1) || sync_hit;
    s_nxt.rx_bit = rx_bnd ? 4'h0 : s_r.rx_bit + 4'h1;
    half_sync    = (s_r.rx_bit == hw - 4'h1)
                   && ((w & (12'hFFF >> (SH_W - hw))) == (sync_pat(s_r.ws) >> lo_w(s_r.ws)));
    dec          = decode(sym, s_r.ws);
    if (rx_bnd && sync_hit)                 s_nxt.aligned = 1'b1;
    if (rx_bnd && dec[11:10] == K_BAD)      s_nxt.aligned = 1'b0;

    // output latch feed: local or cascade
    if (!s_r.cascade) begin
      dgo = rx_bnd;
      dk  = dec[11:10];
      dv  = dec[9:0];
      s_nxt.cap      = 1'b0;
      s_nxt.rel_pend = 1'b0;
    end else begin
      if (s_r.rel_pend && rx_bnd) begin
        dgo            = 1'b1;
        dk             = s_r.held_k;
        dv             = s_r.held_v;
        s_nxt.rel_pend = 1'b0;
      end
      if (s_r.cap && (!s_r.cen_s2 || half_sync || (rx_bnd && sync_hit))) begin
        s_nxt.cap      = 1'b0;
        s_nxt.rel_pend = 1'b1;
      end else if (!s_r.cap && s_r.cen_s2 && rx_bnd && dec[11:10] != K_SYNC) begin
        s_nxt.cap    = 1'b1;
        s_nxt.held_k = dec[11:10];
        s_nxt.held_v = dec[9:0];
      end
    end
    if (dgo) begin
      case (dk)
        K_DATA: begin
          s_nxt.rx_lines = (s_r.rx_lines & ~dmask(s_r.ws)) | ({2'h0, dv} & dmask(s_r.ws));
          s_nxt.dstb     = 1'b1;
          s_nxt.viol     = 1'b0;
        end
        K_CMD: begin
          s_nxt.rx_lines = (s_r.rx_lines & dmask(s_r.ws))
                           | ({2'h0, dv} << (len - 4'h2));
          s_nxt.cstb     = 1'b1;
          s_nxt.viol     = 1'b0;
        end
        K_SYNC: begin
          s_nxt.rx_lines = s_r.rx_lines & dmask(s_r.ws);    // sync clears command
          s_nxt.cstb     = 1'b1;
          s_nxt.viol     = 1'b0;
        end
        default: begin
          s_nxt.viol     = 1'b1;
          s_nxt.dstb     = 1'b1;
        end
      endcase
    end

    // receive byte clock with pulse stretching
    nom = (s_nxt.rx_bit >= (len >> 1));
    if (nom != s_r.rx_clk && s_r.lvl_cnt >= (len >> 1) - 4'h1) begin
      s_nxt.rx_clk  = nom;
      s_nxt.lvl_cnt = 4'h0;
    end else if (s_r.lvl_cnt != 4'hF) begin
      s_nxt.lvl_cnt = s_r.lvl_cnt + 4'h1;
    end

    // synchronous reset
    if (SYS_RST) begin
      s_nxt        = '0;
      s_nxt.wait_r = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK) begin
    s_r <= s_nxt;
  end

  // ----------------------------------------------------------------
  // outputs, each straight from a state flop
  // ----------------------------------------------------------------
  assign READDATA           = s_r.rdata;
  assign WAITREQUEST        = s_r.wait_r;
  assign TX_ACK             = s_r.ack;
  assign TX_BYTE_CLK        = s_r.tx_clk;
  assign SERIAL_OUT         = s_r.tx_line;
  assign CAPTURED_FLAG_OUT  = s_r.cap;
  assign RX_LINES           = s_r.rx_lines;
  assign DATA_OUT_STROBE    = s_r.dstb;
  assign COMMAND_OUT_STROBE = s_r.cstb;
  assign CODE_VIOLATION_OUT = s_r.viol;
  assign RX_BYTE_CLK        = s_r.rx_clk;

endmodule : link_codec

// *** rtl/link_codec_pkg.sv ***
// constants, code tables and register map of the serial link codec
package link_codec_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses) and field positions
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CTRL       = 4'h0;   // width select, cascade mode
  localparam logic [3:0] REG_STATUS     = 4'h4;   // link state, overflow flag
  localparam logic [3:0] REG_RX_LINES   = 4'h8;   // receiver output latch
  localparam int         CTRL_WS_LSB    = 0;      // two-bit width select
  localparam int         CTRL_CASCADE   = 2;      // 1 = cascade capture
  localparam int         STAT_VIOL      = 0;      // code violation level
  localparam int         STAT_ALIGNED   = 1;      // receiver byte aligned
  localparam int         STAT_CAPTURED  = 2;      // captured flag level
  localparam int         STAT_OVERFLOW  = 3;      // sticky, write 1 to clear
  localparam int         STAT_QCNT_LSB  = 4;      // two-bit buffer fill
  localparam logic [31:0] RD_UNMAPPED   = 32'h0000_0000;

  // ----------------------------------------------------------------
  // width select codes and symbol geometry
  // ----------------------------------------------------------------
  localparam logic [1:0] WS_8           = 2'h0;   // 8 data / 4 command
  localparam logic [1:0] WS_9           = 2'h1;   // 9 data / 3 command
  localparam logic [1:0] WS_10          = 2'h2;   // 10 data / 2 command
  localparam logic [3:0] SYM4_W         = 4'h5;   // 4b/5b symbol width
  localparam logic [3:0] SYM5_W         = 4'h6;   // 5b/6b symbol width
  localparam logic [3:0] SH_W           = 4'hC;   // longest serial pattern

  // ----------------------------------------------------------------
  // symbol kinds out of the decoder
  // ----------------------------------------------------------------
  localparam logic [1:0] K_DATA         = 2'h0;
  localparam logic [1:0] K_CMD          = 2'h1;
  localparam logic [1:0] K_SYNC         = 2'h2;
  localparam logic [1:0] K_BAD          = 2'h3;

  // ----------------------------------------------------------------
  // special symbols, never equal to a data code
  // ----------------------------------------------------------------
  localparam logic [5:0] SYNC_HI5       = 6'h18;  // 11000
  localparam logic [5:0] SYNC_LO5       = 6'h11;  // 10001
  // marks open with a one: after a symbol ending in two zeros the line stays flat three bits
  localparam logic [5:0] CMD_MARK5      = 6'h19;  // 11001
  localparam logic [5:0] SYNC_HI6       = 6'h18;  // 011000
  localparam logic [5:0] SYNC_LO6       = 6'h23;  // 100011
  localparam logic [5:0] CMD_MARK6      = 6'h3D;  // 111101

  // ----------------------------------------------------------------
  // data code tables
  // ----------------------------------------------------------------
  localparam logic [4:0] ENC4_TAB [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B,
    5'h0E, 5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
  localparam logic [5:0] ENC5_TAB [32] = '{6'h36, 6'h11, 6'h24, 6'h25, 6'h12, 6'h13,
    6'h16, 6'h17, 6'h22, 6'h31, 6'h37, 6'h27, 6'h32, 6'h33, 6'h34, 6'h35,
    6'h3E, 6'h39, 6'h3A, 6'h3B, 6'h2D, 6'h2E, 6'h2F, 6'h29, 6'h2A, 6'h2B,
    6'h1A, 6'h1B, 6'h19, 6'h2C, 6'h1D, 6'h1E};

endpackage : link_codec_pkg

// *** verification/link_codec_properties.sv ***
// assertions on the serial link codec ports
`timescale 1ns/10ps
module link_codec_properties
  import link_codec_pkg::*;
(
  input wire logic        CORE_CLK,
  input wire logic        SYS_RST,
  input wire logic [3:0]  ADDRESS,
  input wire logic        READ,
  input wire logic        WRITE,
  input wire logic [31:0] READDATA,
  input wire logic        WAITREQUEST,
  input wire logic        TX_ACK,
  input wire logic        TX_BYTE_CLK,
  input wire logic        SERIAL_OUT,
  input wire logic        CAPTURE_ENABLE_IN,
  input wire logic        CAPTURED_FLAG_OUT,
  input wire logic        DATA_OUT_STROBE,
  input wire logic        COMMAND_OUT_STROBE,
  input wire logic        CODE_VIOLATION_OUT,
  input wire logic        RX_BYTE_CLK
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  logic [4:0] warm_r;  // skips the all-zero first byte after reset
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) warm_r <= 5'h00;
    else if (warm_r != 5'h1F) warm_r <= warm_r + 5'h01;
  end
  // request, answer one cycle later, then busy again
  sequence s_req; (READ || WRITE) && WAITREQUEST; endsequence
  sequence s_answer; !WAITREQUEST ##1 WAITREQUEST; endsequence
  sequence s_flat3; (warm_r == 5'h1F && $stable(SERIAL_OUT))[*3]; endsequence
  AST_BUS_ANSWER: assert property (s_req |=> s_answer) else $error("bus answer late");
  AST_RD_UNMAPPED: assert property (READ && ADDRESS == 4'hC && !WAITREQUEST
    |-> READDATA == RD_UNMAPPED) else $error("unmapped read not zero");
  AST_NRZI_RUN: assert property (s_flat3 |=> $changed(SERIAL_OUT))
    else $error("line flat too long");
  AST_TX_BOUNDARY: assert property ($fell(TX_BYTE_CLK) |=>
    (!$fell(TX_BYTE_CLK))[*8]) else $error("byte boundary too soon");
  AST_RX_CLK_HI: assert property ($rose(RX_BYTE_CLK) |-> RX_BYTE_CLK[*5])
    else $error("byte clock high too short");
  AST_RX_CLK_LO: assert property ($fell(RX_BYTE_CLK) |-> !RX_BYTE_CLK[*5])
    else $error("byte clock low too short");
  AST_VIOL_RISE: assert property ($rose(CODE_VIOLATION_OUT) |-> DATA_OUT_STROBE)
    else $error("violation without strobe");
  AST_VIOL_FALL: assert property ($fell(CODE_VIOLATION_OUT) |->
    DATA_OUT_STROBE || COMMAND_OUT_STROBE) else $error("violation fell without decode");
  AST_STROBE_ONE: assert property (!(DATA_OUT_STROBE && COMMAND_OUT_STROBE))
    else $error("both strobes high");
  AST_ACK_PULSE: assert property (TX_ACK |=> !TX_ACK)
    else $error("ack longer than one cycle");
  AST_FLAG_DROP: assert property ((!CAPTURE_ENABLE_IN)[*4] |->
    !CAPTURED_FLAG_OUT) else $error("flag high with enable low");
endmodule : link_codec_properties
bind link_codec link_codec_properties u_link_codec_properties (
  .CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .ADDRESS(ADDRESS), .READ(READ),
  .WRITE(WRITE), .READDATA(READDATA), .WAITREQUEST(WAITREQUEST), .TX_ACK(TX_ACK),
  .TX_BYTE_CLK(TX_BYTE_CLK), .SERIAL_OUT(SERIAL_OUT), .CAPTURE_ENABLE_IN(CAPTURE_ENABLE_IN),
  .CAPTURED_FLAG_OUT(CAPTURED_FLAG_OUT), .DATA_OUT_STROBE(DATA_OUT_STROBE),
  .COMMAND_OUT_STROBE(COMMAND_OUT_STROBE), .CODE_VIOLATION_OUT(CODE_VIOLATION_OUT),
  .RX_BYTE_CLK(RX_BYTE_CLK));

// *** verification/serial_media_model.sv ***
// serial media between the transmitter line and the differential receiver
`timescale 1ns/10ps
module serial_media_model (
  input  wire logic clk,
  input  wire logic line_in,
  input  wire logic corrupt,
  output logic      pos,
  output logic      neg
);
  // one bit of media delay; corrupt inverts the line for that bit
  always_ff @(posedge clk) begin
    pos <= line_in ^ corrupt;
    neg <= ~(line_in ^ corrupt);
  end
endmodule : serial_media_model

// *** verification/tb_top.sv ***
// self-checking bench for the serial link codec
`timescale 1ns/10ps
module tb_top;
  import link_codec_pkg::*;
  logic        clk = 1'b0, sys_rst = 1'b1, read = 1'b0, write = 1'b0;
  logic        input_strobe = 1'b0, corrupt = 1'b0, cascade = 1'b0;
  logic        seen_viol = 1'b0, seen_flag = 1'b0;
  logic        waitrequest, tx_ack, tx_bclk, serial_out, pos, neg, flag, dstb, cstb, viol;
  logic        rx_bclk;
  logic [3:0]  address = 4'h0;
  logic [11:0] tx_lines = 12'h000, dmask = 12'h0FF, rx_lines, d;
  logic [31:0] writedata = 32'h0, readdata, rd;
  logic [11:0] exp_q[$], msk_q[$];
  int          n_mismatch = 0, checked = 0, seed = 22104;
  wire         cap_en = cascade ? 1'b1 : rx_bclk;  // chain head or tie
  always #20 clk = ~clk;
  link_codec u_link_codec (.CORE_CLK(clk), .SYS_RST(sys_rst), .ADDRESS(address),
    .READ(read), .WRITE(write), .WRITEDATA(writedata), .READDATA(readdata),
    .WAITREQUEST(waitrequest), .INPUT_STROBE(input_strobe), .TX_LINES(tx_lines),
    .TX_ACK(tx_ack), .TX_BYTE_CLK(tx_bclk), .SERIAL_OUT(serial_out), .SERIAL_IN_POS(pos),
    .SERIAL_IN_NEG(neg), .CAPTURE_ENABLE_IN(cap_en), .CAPTURED_FLAG_OUT(flag),
    .RX_LINES(rx_lines), .DATA_OUT_STROBE(dstb), .COMMAND_OUT_STROBE(cstb),
    .CODE_VIOLATION_OUT(viol), .RX_BYTE_CLK(rx_bclk));
  serial_media_model u_serial_media_model (.clk(clk), .line_in(serial_out),
    .corrupt(corrupt), .pos(pos), .neg(neg));
  // one bus cycle, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                     output logic [31:0] q);
    address <= a;
    writedata <= wd;
    read <= !wr;
    write <= wr;
    @(posedge clk);
    while (waitrequest !== 1'b0) @(posedge clk);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t reg got %h exp %h", $time, got, exp);
    end
  endtask : chk_reg
  task automatic chk_rx(input logic [11:0] got, input logic [11:0] exp, input logic [11:0] m);
    checked++;
    if ((got & m) !== (exp & m)) begin
      n_mismatch++;
      $display("[ERR] %0t lines got %h exp %h", $time, got, exp);
    end
  endtask : chk_rx
  // strobe one byte, note the expectation, hold until acknowledged
  task automatic send(input logic [11:0] v, input logic [11:0] m);
    tx_lines <= v;
    @(posedge clk);
    input_strobe <= 1'b1;  // strobe launched on the clock edge
    exp_q.push_back(v);
    msk_q.push_back(m);
    do @(posedge clk); while (tx_ack !== 1'b1);
    input_strobe <= 1'b0;
    repeat (3) @(posedge clk);  // strobe low gap
  endtask : send
  // receive side: compare each delivered data or command byte in order
  always @(posedge clk) begin
    if (viol === 1'b1) seen_viol <= 1'b1;
    if (flag === 1'b1) seen_flag <= 1'b1;
    if (sys_rst === 1'b0 && viol === 1'b0 && exp_q.size() > 0 && (dstb === 1'b1 ||
        (cstb === 1'b1 && (rx_lines & ~dmask) !== 12'h000))) begin
      chk_rx(rx_lines, exp_q.pop_front(), msk_q.pop_front());
    end
  end
  task automatic test_done;
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    test_done();
  end
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    bus(1'b0, REG_CTRL, 32'h0, rd);
    chk_reg(rd, 32'h0);
    bus(1'b0, 4'hC, 32'h0, rd);
    chk_reg(rd, RD_UNMAPPED);
    for (int w = 0; w < 3; w++) begin
      bus(1'b1, REG_CTRL, 32'(w), rd);
      bus(1'b0, REG_CTRL, 32'h0, rd);
      chk_reg(rd, 32'(w));
      dmask = 12'hFFF >> (4 - w);
      repeat (60) @(posedge clk);  // realign on sync
      send(dmask + 12'h001, ~dmask);  // smallest command
      repeat (6) begin
        d = 12'($random(seed));
        send(d & dmask, dmask);
      end
      send(~dmask, ~dmask);  // largest command
      repeat (60) @(posedge clk);
      bus(1'b0, REG_RX_LINES, 32'h0, rd);
      chk_reg(rd, {20'h0, d & dmask});  // idle syncs clear commands
    end
    corrupt <= 1'b1;
    @(posedge clk);
    corrupt <= 1'b0;
    repeat (60) @(posedge clk);
    chk_reg({31'h0, seen_viol}, 32'h1);
    d = 12'($random(seed));
    send(d & dmask, dmask);  // decode resumes after realign
    bus(1'b1, REG_CTRL, 32'(1 << CTRL_CASCADE) | 32'(WS_10), rd);
    cascade <= 1'b1;
    repeat (30) @(posedge clk);
    send(~d & dmask, dmask);  // held byte released on sync
    repeat (60) @(posedge clk);
    chk_reg({31'h0, seen_flag}, 32'h1);
    chk_reg(32'(exp_q.size()), 32'h0);
    bus(1'b1, REG_STATUS, 32'(1 << STAT_OVERFLOW), rd);
    bus(1'b0, REG_STATUS, 32'h0, rd);
    chk_reg(rd, 32'(1 << STAT_ALIGNED));
    test_done();
  end
endmodule : tb_top
